// ==== core/flash_ecc_map.vh ====
/*
 * Register map, field positions, encodings and reset values of the
 * flash ECC status tracker.
 * Assumes byte addresses on a 4-bit register port, 32-bit data words.
 */
`ifndef FLASH_ECC_MAP_VH
`define FLASH_ECC_MAP_VH

// ==================================================================
// register offsets
`define ADDR_W 4
`define OFS_STATUS 4'h0
`define OFS_IRQ_STS 4'h4
`define OFS_IRQ_MASK 4'h8
`define OFS_CTRL 4'hC

// ==================================================================
// flash_ecc_status fields
`define ARR1_CNT_HI 24
`define ARR1_CNT_LO 22
`define ARR0_CNT_HI 19
`define ARR0_CNT_LO 17
`define SIG_RES_HI 15
`define SIG_RES_LO 14
`define SIG_FAIL_BIT 13
`define ARR1_RES_HI 12
`define ARR1_RES_LO 11
`define ARR0_RES_HI 10
`define ARR0_RES_LO 9
`define CNT_W 3

// ==================================================================
// 2-bit ECC result encodings
`define RESULT_CLEAN 2'h0
`define RESULT_UNCORRECTED 2'h1
`define RESULT_CORRECTED 2'h2
`define RESULT_BOTH_KINDS 2'h3

// ==================================================================
// control register: per-array enable of result capture, counting and events
`define CTRL_W 2
`define CTRL_RST 2'h0

// ==================================================================
// interrupt status / mask bits
`define IRQ_W 5
`define IRQ_ARR0_CORR 0
`define IRQ_ARR0_UNCORR 1
`define IRQ_ARR1_CORR 2
`define IRQ_ARR1_UNCORR 3
`define IRQ_SIG_FAIL 4
`define IRQ_RST 5'h00

`endif

// ==== core/ecc_result_field.v ====
/*
 * One sticky 2-bit ECC result field, cleared by a status read.
 * Assumes single/double qualifiers are only meaningful with i_valid.
 */
`timescale 1ns/1ns
`include "flash_ecc_map.vh"

module ecc_result_field (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_en,
    input wire i_valid,
    input wire i_single,
    input wire i_double,
    input wire i_clr,
    output wire [1:0] o_next,
    output reg [1:0] o_field
);

reg [1:0] base;
reg [1:0] field_d;

// ==================================================================
// merge: an event in the read cycle survives the clear
always @* begin
    base = i_clr ? `RESULT_CLEAN : o_field;
    field_d = base;
    if (i_en && i_valid) begin
        field_d = base | {i_single, i_double};
    end
end

assign o_next = field_d;

always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_field <= `RESULT_CLEAN;
    end else begin
        o_field <= field_d;
    end
end

endmodule // ecc_result_field

// ==== core/sat_err_counter.v ====
/*
 * Saturating event counter, cleared by a status read.
 * Assumes i_inc is at most one event per clock.
 */
`timescale 1ns/1ns

module sat_err_counter #(
    parameter W = 3
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_inc,
    input wire i_clr,
    output reg [W-1:0] o_count
);

localparam [W-1:0] MAX = {W{1'b1}};
localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

// ==================================================================
// counter
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_count <= {W{1'b0}};
    end else if (i_clr) begin
        // an error seen during the read is the first of the next run
        o_count <= i_inc ? ONE : {W{1'b0}};
    end else if (i_inc && o_count != MAX) begin
        o_count <= o_count + ONE;
    end
end

endmodule // sat_err_counter

// ==== core/flash_ecc_status_tracker.v ====
/*
 * Flash ECC status tracker: status register with read-clear array ECC
 * fields, per-array 1-bit error counters, power-up signature check
 * sequencing and an interrupt block.
 * Assumes the flash arrays report one read result per clock at most,
 * and the signature engine answers a start pulse with a done pulse.
 */
`timescale 1ns/1ns
`include "flash_ecc_map.vh"

module flash_ecc_status_tracker #(
    parameter CNT_W = `CNT_W
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_dbg_sel,
    output reg [31:0] o_rdata,
    input wire [1:0] i_rd_valid,
    input wire [1:0] i_rd_single,
    input wire [1:0] i_rd_double,
    output reg o_sig_chk_start,
    input wire i_sig_chk_done,
    input wire i_sig_chk_pass,
    input wire i_sig_single,
    input wire i_sig_double,
    input wire i_sig_prog_wr,
    input wire i_sig_prog_match,
    output reg o_user_exec_en,
    output reg o_irq
);

// ==================================================================
// signature check sequencer states
localparam [1:0] S_BOOT = 2'h0;
localparam [1:0] S_START = 2'h1;
localparam [1:0] S_WAIT = 2'h2;
localparam [1:0] S_DONE = 2'h3;

// ==================================================================
// declarations
wire sel_status;
wire sel_irq_sts;
wire sel_irq_mask;
wire sel_ctrl;
wire status_rd;
wire [1:0] field_q [0:1];
wire [1:0] field_next [0:1];
wire [CNT_W-1:0] count_q [0:1];
wire [1:0] cnt_inc;
wire [1:0] arr_corr_evt;
wire [1:0] arr_unc_evt;
wire sig_fail_evt;
wire sig_wait;
wire sig_done_evt;
wire ctrl_wr;
wire mask_wr;
wire sts_wr;
wire [`IRQ_W-1:0] irq_evt;

// named views of the status register fields
wire [CNT_W-1:0] array1_single_err_count;
wire [CNT_W-1:0] array0_single_err_count;
wire [1:0] signature_ecc_result;
wire signature_fail_flag;
wire [1:0] array1_read_ecc_result;
wire [1:0] array0_read_ecc_result;

reg [`CTRL_W-1:0] ctrl_q;
reg [`IRQ_W-1:0] irq_sts_q;
reg [`IRQ_W-1:0] irq_sts_d;
reg [`IRQ_W-1:0] irq_mask_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg sig_fail_q;
reg sig_fail_d;
reg [1:0] sig_res_q;
reg [1:0] sig_res_d;
reg [31:0] status_word;
reg [31:0] rdata_d;

// ==================================================================
// address decode
assign sel_status = (i_addr == `OFS_STATUS);
assign sel_irq_sts = (i_addr == `OFS_IRQ_STS);
assign sel_irq_mask = (i_addr == `OFS_IRQ_MASK);
assign sel_ctrl = (i_addr == `OFS_CTRL);

// any status read clears, debug or not, so a debugger read is
// destructive just like a processor read
assign status_rd = i_rd && sel_status;

// ==================================================================
// write decode; writes to the status register fall on the floor
// and leave the read-clear fields alone
assign ctrl_wr = i_wr && sel_ctrl;
assign mask_wr = i_wr && sel_irq_mask;
assign sts_wr = i_wr && sel_irq_sts;

// ==================================================================
// per-array read result field and 1-bit error counter
genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_arr
        ecc_result_field u_field (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .i_en(ctrl_q[g]),
            .i_valid(i_rd_valid[g]),
            .i_single(i_rd_single[g]),
            .i_double(i_rd_double[g]),
            .i_clr(status_rd),
            .o_next(field_next[g]),
            .o_field(field_q[g])
        );

        // count only while the field stays at corrected-only, so any
        // 2-bit error in the run freezes the counter
        assign cnt_inc[g] = ctrl_q[g] && i_rd_valid[g] &&
            i_rd_single[g] && !i_rd_double[g] &&
            (field_next[g] == `RESULT_CORRECTED);

        sat_err_counter #(
            .W(CNT_W)
        ) u_cnt (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .i_inc(cnt_inc[g]),
            .i_clr(status_rd),
            .o_count(count_q[g])
        );

        assign arr_corr_evt[g] = ctrl_q[g] && i_rd_valid[g] &&
            i_rd_single[g];
        assign arr_unc_evt[g] = ctrl_q[g] && i_rd_valid[g] &&
            i_rd_double[g];
    end
endgenerate

// ==================================================================
// signature check after reset
always @* begin
    state_d = state_q;
    case (state_q)
        S_BOOT: begin
            state_d = S_START;
        end
        S_START: begin
            state_d = S_WAIT;
        end
        S_WAIT: begin
            if (i_sig_chk_done) begin
                state_d = S_DONE;
            end
        end
        S_DONE: begin
            state_d = S_DONE;
        end
        default: begin
            state_d = S_BOOT;
        end
    endcase
end

// done is only believed while waiting, so a stray or repeated done
// pulse after the check cannot rewrite the result
assign sig_wait = (state_q == S_WAIT);
assign sig_done_evt = sig_wait && i_sig_chk_done;
assign sig_fail_evt = sig_done_evt && !i_sig_chk_pass;

always @* begin
    sig_fail_d = sig_fail_q;
    if (i_sig_prog_wr && i_sig_prog_match) begin
        sig_fail_d = 1'b0;
    end
    if (sig_fail_evt) begin
        sig_fail_d = 1'b1;
    end
end

// result of the check is held until the next reset, not read-cleared
always @* begin
    sig_res_d = sig_res_q;
    if (sig_done_evt) begin
        sig_res_d = {i_sig_single, i_sig_double};
    end
end

always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        state_q <= S_BOOT;
        sig_fail_q <= 1'b0;
        sig_res_q <= `RESULT_CLEAN;
    end else begin
        state_q <= state_d;
        sig_fail_q <= sig_fail_d;
        sig_res_q <= sig_res_d;
    end
end

// outputs are decoded from the next state so that they leave
// flip-flops in step with the state register
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_sig_chk_start <= 1'b0;
    end else begin
        o_sig_chk_start <= (state_d == S_START);
    end
end

always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_user_exec_en <= 1'b0;
    end else begin
        // user code stays held off until the check passes or a matching signature is programmed
        o_user_exec_en <= (state_d == S_DONE) && !sig_fail_d;
    end
end

// ==================================================================
// control and interrupt registers
assign irq_evt[`IRQ_ARR0_CORR] = arr_corr_evt[0];
assign irq_evt[`IRQ_ARR0_UNCORR] = arr_unc_evt[0];
assign irq_evt[`IRQ_ARR1_CORR] = arr_corr_evt[1];
assign irq_evt[`IRQ_ARR1_UNCORR] = arr_unc_evt[1];
assign irq_evt[`IRQ_SIG_FAIL] = sig_fail_evt;

// write-one-to-clear; a new event in the same cycle wins
always @* begin
    irq_sts_d = irq_sts_q;
    if (sts_wr) begin
        irq_sts_d = irq_sts_q & ~i_wdata[`IRQ_W-1:0];
    end
    irq_sts_d = irq_sts_d | irq_evt;
end

// control: bit g enables result capture and events of array g
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        ctrl_q <= `CTRL_RST;
    end else if (ctrl_wr) begin
        ctrl_q <= i_wdata[`CTRL_W-1:0];
    end
end

// a masked bit still records; only the line is gated
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        irq_mask_q <= `IRQ_RST;
    end else if (mask_wr) begin
        irq_mask_q <= i_wdata[`IRQ_W-1:0];
    end
end

// sticky status; the merge above does the write-one-to-clear
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        irq_sts_q <= `IRQ_RST;
    end else begin
        irq_sts_q <= irq_sts_d;
    end
end

// the line follows the next status so it rises at the same edge as
// the sticky bit; a mask change takes effect one cycle later
always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_irq <= 1'b0;
    end else begin
        o_irq <= |(irq_sts_d & irq_mask_q);
    end
end

// ==================================================================
// named views of the status fields
assign array1_single_err_count = count_q[1];
assign array0_single_err_count = count_q[0];
assign signature_ecc_result = sig_res_q;
// failure flag hidden from the processor's own reads
assign signature_fail_flag = sig_fail_q && i_dbg_sel;
assign array1_read_ecc_result = field_q[1];
assign array0_read_ecc_result = field_q[0];

// ==================================================================
// status word assembly; bit 16 and the gaps read as zero
always @* begin
    status_word = 32'h0000_0000;
    status_word[`ARR1_CNT_HI:`ARR1_CNT_LO] = array1_single_err_count;
    status_word[`ARR0_CNT_HI:`ARR0_CNT_LO] = array0_single_err_count;
    status_word[`SIG_RES_HI:`SIG_RES_LO] = signature_ecc_result;
    status_word[`SIG_FAIL_BIT] = signature_fail_flag;
    status_word[`ARR1_RES_HI:`ARR1_RES_LO] = array1_read_ecc_result;
    status_word[`ARR0_RES_HI:`ARR0_RES_LO] = array0_read_ecc_result;
end

// ==================================================================
// read port: data in the cycle after the strobe, zero otherwise
// reads have no side effect apart from the status read-clear
always @* begin
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
        case (i_addr)
            `OFS_STATUS: begin
                rdata_d = status_word;
            end
            `OFS_IRQ_STS: begin
                rdata_d[`IRQ_W-1:0] = irq_sts_q;
            end
            `OFS_IRQ_MASK: begin
                rdata_d[`IRQ_W-1:0] = irq_mask_q;
            end
            `OFS_CTRL: begin
                rdata_d[`CTRL_W-1:0] = ctrl_q;
            end
            default: begin
                // unmapped offsets read as zero
                rdata_d = 32'h0000_0000;
            end
        endcase
    end
end

always @(posedge i_mclk) begin
    if (!i_rst_n) begin
        o_rdata <= 32'h0000_0000;
    end else begin
        o_rdata <= rdata_d;
    end
end

endmodule // flash_ecc_status_tracker

// ==== bench/sig_engine.sv ====
/* signature check engine on the far side of the tracker.
   assumes one start pulse per reset; i_cfg is {pass,single,double} */
`timescale 1ns/1ns
module sig_engine (
    input wire i_mclk,
    input wire i_start,
    input wire [2:0] i_cfg,
    output reg o_done,
    output wire o_pass,
    output wire o_single,
    output wire o_double
);
    reg [3:0] wait_q = 4'h0;
    initial o_done = 1'b0;
    // delay varies with i_cfg, so the check answers fast and slow
    always @(posedge i_mclk) begin
        o_done <= (wait_q == 4'h1);
        if (i_start)
            wait_q <= {i_cfg, 1'b1};
        else if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
    end
    // qualifiers are only held with done; otherwise show the inverse
    assign {o_pass, o_single, o_double} = o_done ? i_cfg : ~i_cfg;
endmodule // sig_engine

// ==== bench/tracker_properties.sv ====
/* port assertions for the flash ECC status tracker.
   assumes the register map header and a bind to the top module */
`timescale 1ns/1ns
`include "flash_ecc_map.vh"
module tracker_properties (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [3:0] i_addr,
    input wire i_rd,
    input wire i_dbg_sel,
    input wire [31:0] o_rdata,
    input wire [1:0] i_rd_valid,
    input wire [1:0] i_rd_double,
    input wire i_sig_prog_wr,
    input wire i_sig_prog_match,
    input wire o_sig_chk_start,
    input wire o_user_exec_en
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // read sequences
    sequence s_rd;
        i_rd && i_addr == `OFS_STATUS && i_rd_valid == 2'h0;
    endsequence
    sequence s_gap;
        !i_rd && i_rd_valid == 2'h0;
    endsequence
    sequence s_dbl;
        !i_rd && i_rd_valid == 2'h2 && i_rd_double[1];
    endsequence
    a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero");
    a_start_after_reset: assert property (
        $rose(i_rst_n) |-> ##[1:3] o_sig_chk_start)
        else $error("no check start after reset");
    a_start_one_cycle: assert property (
        o_sig_chk_start |=> !o_sig_chk_start)
        else $error("start pulse too long");
    a_dbg_hides_fail: assert property (
        s_rd ##0 !i_dbg_sel |=> !o_rdata[`SIG_FAIL_BIT])
        else $error("fail bit seen off debug path");
    a_fail_blocks_exec: assert property (
        s_rd ##0 i_dbg_sel ##1 o_rdata[`SIG_FAIL_BIT] |-> !o_user_exec_en)
        else $error("user code enabled while failed");
    a_prog_unblocks: assert property (
        i_sig_prog_wr && i_sig_prog_match |=> o_user_exec_en)
        else $error("good signature did not unblock");
    a_reserved_zero: assert property (
        i_rd |=> o_rdata[31:25] == 7'h0 && o_rdata[21:20] == 2'h0
            && !o_rdata[16])
        else $error("reserved bits set");
    a_clear_on_read: assert property (
        s_rd ##1 s_gap ##1 s_rd |=> o_rdata[24:17] == 8'h0
            && o_rdata[12:9] == 4'h0)
        else $error("status not cleared by read");
    a_double_no_count: assert property (
        s_rd ##1 s_gap ##1 s_dbl ##1 s_gap ##1 s_rd
            |=> o_rdata[24:22] == 3'h0)
        else $error("double error counted");
endmodule // tracker_properties
bind flash_ecc_status_tracker tracker_properties u_tracker_properties (
    .i_mclk, .i_rst_n, .i_addr, .i_rd, .i_dbg_sel, .o_rdata, .i_rd_valid,
    .i_rd_double, .i_sig_prog_wr, .i_sig_prog_match, .o_sig_chk_start,
    .o_user_exec_en);

// ==== bench/test_flash_ecc_status_tracker.sv ====
/* self-checking bench for the flash ECC status tracker.
   assumes sig_engine as the signature side and the register map header */
`timescale 1ns/1ns
`include "flash_ecc_map.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    fail_count = fail_count + 1; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_ecc_status_tracker;
    reg i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_dbg_sel = 0;
    reg i_sig_prog_wr = 0, i_sig_prog_match = 0, fail;
    reg [3:0] i_addr = 0;
    reg [31:0] i_wdata = 0, rd_q, exp_w, seed = 32'hf95d0348;
    reg [1:0] i_rd_valid = 0, i_rd_single = 0, i_rd_double = 0, sig;
    reg [2:0] cfg = 0;
    wire [31:0] o_rdata;
    wire o_sig_chk_start, done, pass, sgl, dbl, o_user_exec_en, o_irq;
    integer fail_count = 0, compares = 0, cyc = 0, k, m, n, a;
    integer cnt[0:1], fld[0:1], ctrl, mask, sts;
    flash_ecc_status_tracker u_flash_ecc_status_tracker (.i_mclk, .i_rst_n,
        .i_addr, .i_wdata, .i_wr, .i_rd, .i_dbg_sel, .o_rdata, .i_rd_valid,
        .i_rd_single, .i_rd_double, .o_sig_chk_start, .i_sig_chk_done(done),
        .i_sig_chk_pass(pass), .i_sig_single(sgl), .i_sig_double(dbl),
        .i_sig_prog_wr, .i_sig_prog_match, .o_user_exec_en, .o_irq);
    sig_engine u_sig_engine (.i_mclk, .i_start(o_sig_chk_start),
        .i_cfg(cfg), .o_done(done), .o_pass(pass), .o_single(sgl),
        .o_double(dbl));
    always #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    // ==========
    // bus, event and model tasks
    task wr(input [3:0] ad, input [31:0] d);
        begin
            @(posedge i_mclk);
            i_wr <= 1; i_addr <= ad; i_wdata <= d;
            @(posedge i_mclk);
            i_wr <= 0;
        end
    endtask
    task rd(input [3:0] ad);
        begin
            @(posedge i_mclk);
            i_rd <= 1; i_addr <= ad;
            @(posedge i_mclk);
            i_rd <= 0;
            #1 rd_q = o_rdata;
        end
    endtask
    task st(input dbg);
        begin
            i_dbg_sel <= dbg;
            exp_w = {7'h0, cnt[1][2:0], 2'h0, cnt[0][2:0], 1'b0, sig,
                fail & dbg, fld[1][1:0], fld[0][1:0], 9'h0};
            rd(`OFS_STATUS);
            `CHK(rd_q, exp_w)
            cnt[0] = 0; cnt[1] = 0; fld[0] = 0; fld[1] = 0;
        end
    endtask
    task ev(input integer g, input s, input d);
        begin
            @(posedge i_mclk);
            i_rd_valid <= 2'h1 << g; i_rd_single <= {s, s};
            i_rd_double <= {d, d};
            @(posedge i_mclk);
            i_rd_valid <= 0; i_rd_single <= ~{s, s}; i_rd_double <= ~{d, d};
            if (ctrl[g]) begin
                fld[g] = fld[g] | {s, d};
                if (s && fld[g] == 2 && cnt[g] < 7) cnt[g] = cnt[g] + 1;
                sts = sts | ({d, s} << 2 * g);
            end
        end
    endtask
    task irq_chk;
        begin
            rd(`OFS_IRQ_STS);
            `CHK(rd_q, sts)
            `CHK(o_irq, (sts & mask) != 0)
        end
    endtask
    task report_and_stop;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ==========
    // main sequence
    initial begin
        for (k = 0; k < 8; k = k + 1) begin
            cfg = k;
            @(posedge i_mclk);
            i_rst_n <= 0;
            repeat (10) @(posedge i_mclk);
            i_rst_n <= 1;
            cnt[0] = 0; cnt[1] = 0; fld[0] = 0; fld[1] = 0;
            ctrl = 0; mask = 0; sig = cfg[1:0]; fail = !cfg[2];
            sts = fail ? 16 : 0;
            n = 0;
            while (done !== 1'b1 && n < 80) begin
                @(posedge i_mclk) #1;
                n = n + 1;
            end
            @(posedge i_mclk) #1;
            `CHK(o_user_exec_en, !fail)
            st(1);
            st(0);
            if (fail) begin
                mask = 16;
                wr(`OFS_IRQ_MASK, 32'h10);
                irq_chk;
                wr(`OFS_IRQ_STS, 32'hFFFFFFFF);
                sts = 0;
                irq_chk;
                for (m = 0; m < 2; m = m + 1) begin
                    @(posedge i_mclk);
                    i_sig_prog_wr <= 1; i_sig_prog_match <= m;
                    @(posedge i_mclk);
                    i_sig_prog_wr <= 0; i_sig_prog_match <= !m;
                    @(posedge i_mclk) #1;
                    fail = !m;
                    `CHK(o_user_exec_en, !fail)
                end
                st(1);
            end
        end
        $display("signature test done");
        rd(4'h2);
        `CHK(rd_q, 32'h0)
        for (k = 0; k < 12; k = k + 1) begin
            ctrl = $random(seed) & 3;
            mask = $random(seed) & 31;
            wr(`OFS_CTRL, ctrl);
            wr(`OFS_IRQ_MASK, mask);
            rd(`OFS_CTRL);
            `CHK(rd_q, ctrl)
            repeat (10) begin
                a = $random(seed) & 1;
                ev(a, ($random(seed) & 3) != 0, ($random(seed) & 7) == 0);
            end
            irq_chk;
            st($random(seed) & 1);
            m = $random(seed);
            wr(`OFS_IRQ_STS, m);
            sts = sts & ~m;
            irq_chk;
        end
        $display("random event test done");
        ctrl = 3;
        wr(`OFS_CTRL, 3);
        repeat (9) ev(1, 1, 0);
        wr(`OFS_STATUS, 32'hFFFFFFFF);
        st(0);
        st(0);
        ev(1, 1, 1);
        st(0);
        ev(1, 0, 1);
        ev(1, 1, 0);
        st(0);
        $display("counter test done");
        report_and_stop;
    end
endmodule // test_flash_ecc_status_tracker
